// [pkg/swc_pkg.sv]
/*
  Package for the sleep and wake-up controller: register offsets, field
  positions, reset values, timing counts, state encoding and carrier structs.
  Assumes a single 250 MHz clock and an Avalon-MM register master.
*/
`default_nettype none
package swc_pkg;
  // ----------------------------------------------------------------
  // Register map (word byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] SWC_ADDR_STATUS  = 4'h0;
  localparam logic [3:0] SWC_ADDR_IRQCTL  = 4'h4;
  localparam logic [3:0] SWC_ADDR_WDTCTL  = 4'h8;
  localparam logic [3:0] SWC_ADDR_WDTCNT  = 4'hC;

  // Status fields
  localparam int SWC_ST_PD    = 0;
  localparam int SWC_ST_TO    = 1;
  localparam int SWC_ST_SLEEP = 2;
  localparam int SWC_ST_OSC   = 3;
  // Interrupt control fields
  localparam int SWC_IC_GIE   = 7;
  localparam int SWC_IC_EDGE_IRQ_ENABLE  = 4;
  localparam int SWC_IC_PORT_CHANGE_ENABLE  = 3;
  localparam int SWC_IC_CMIE  = 5;
  localparam int SWC_IC_EDGE_IRQ_FLAG  = 1;
  localparam int SWC_IC_PORT_CHANGE_FLAG  = 0;
  localparam int SWC_IC_CMIF  = 6;
  // Watchdog control field
  localparam int SWC_WC_EN    = 0;

  localparam logic [7:0]  SWC_IRQCTL_RST = 8'h00;
  localparam logic [31:0] SWC_RD_UNMAPPED = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SWC_CLK_MHZ       = 250;
  localparam int SWC_OST_NS        = 4096;
  localparam int SWC_OST_CYC       = (SWC_OST_NS * SWC_CLK_MHZ) / 1000;
  localparam int SWC_WDT_W         = 16;
  localparam logic [SWC_WDT_W-1:0] SWC_WDT_LIMIT = 16'hFFFF;
  localparam logic [12:0] SWC_IRQ_VECTOR = 13'h0004;

  // ----------------------------------------------------------------
  // States (one-hot)
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SWC_RUN    = 5'b0_0001,
    SWC_SLEEP  = 5'b0_0010,
    SWC_OST    = 5'b0_0100,
    SWC_RESUME = 5'b0_1000,
    SWC_VECTOR = 5'b1_0000
  } swc_state_t;

  // Wake-up interrupt sources
  typedef struct packed {
    logic edge_irq_pin;
    logic port_hi_change;
    logic cmp_change;
  } swc_src_t;

  // Port drive state
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } swc_port_t;
endpackage
`default_nettype wire

// [hdl/swc_core.sv]
/*
  Sleep and wake-up controller of a small 8-bit core: sleep entry, watchdog,
  status flags, wake-up decision, vectoring and port hold.
  Assumes the sequencer pulses sleep_exec_i and honours the run/stall outputs.
*/
// Chosen here: the address map and the Avalon-MM register port.
`default_nettype none
module swc_core
  import swc_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  // Avalon-MM slave
  input  wire logic [3:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  // Sequencer
  input  wire logic                sleep_exec_i,
  input  wire logic                clrwdt_i,
  input  wire logic [12:0]         pc_i,
  output logic                     prefetch_o,
  output logic      [12:0]         fetch_addr_o,
  output logic                     core_run_o,
  output logic                     vector_o,
  // Pins and sources
  input  wire logic                master_clear_pin_n_i,
  input  wire logic [7:4]          port_hi_i,
  input  wire swc_pkg::swc_src_t   src_evt_i,
  input  wire swc_pkg::swc_port_t  port_core_i,
  output swc_pkg::swc_port_t       port_pin_o,
  output logic                     osc_drv_en_o,
  output logic                     dev_reset_o,
  output logic                     master_clear_oe_o
);
  import swc_pkg::*;

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  swc_state_t            state_r, state_nxt;
  logic                  pd_r, to_r;
  logic [7:0]            irqctl_r;
  logic                  wdt_en_r;
  logic [SWC_WDT_W-1:0]  wdt_cnt_r;
  logic [15:0]           ost_cnt_r;
  logic [7:4]            port_hi_q_r;
  logic                  wake_wdt_r;
  logic                  ack_r;
  logic                  por_done_r;
  logic [12:0]           resume_pc_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire in_sleep    = (state_r == SWC_SLEEP);
  wire running     = (state_r == SWC_RUN);
  wire sleep_go    = running && sleep_exec_i;
  wire wdt_expire  = wdt_en_r && (wdt_cnt_r == SWC_WDT_LIMIT);
  wire change_evt  = |(port_hi_i ^ port_hi_q_r);
  wire set_edge_irq_flag    = src_evt_i.edge_irq_pin;
  wire set_port_change_flag    = src_evt_i.port_hi_change || change_evt;
  wire set_cmif    = src_evt_i.cmp_change;
  wire irq_pend    = (irqctl_r[SWC_IC_EDGE_IRQ_ENABLE] && irqctl_r[SWC_IC_EDGE_IRQ_FLAG])
                  || (irqctl_r[SWC_IC_PORT_CHANGE_ENABLE] && irqctl_r[SWC_IC_PORT_CHANGE_FLAG])
                  || (irqctl_r[SWC_IC_CMIE] && irqctl_r[SWC_IC_CMIF]);
  wire wake_irq    = in_sleep && irq_pend;
  wire wake_wdt    = in_sleep && wdt_expire;
  wire wake_any    = wake_irq || wake_wdt;
  wire master_clear_pin_rst    = !master_clear_pin_n_i;
  wire ost_done    = (ost_cnt_r == 16'(SWC_OST_CYC - 1));
  wire global_irq_enable         = irqctl_r[SWC_IC_GIE];

  wire sel_status  = (avs_address_i == SWC_ADDR_STATUS);
  wire sel_irqctl  = (avs_address_i == SWC_ADDR_IRQCTL);
  wire sel_wdtctl  = (avs_address_i == SWC_ADDR_WDTCTL);
  wire sel_wdtcnt  = (avs_address_i == SWC_ADDR_WDTCNT);
  wire req         = (avs_read_i || avs_write_i) && !ack_r;
  // Writes land on the edge where waitrequest is seen low
  wire wr_irqctl   = avs_write_i && ack_r && sel_irqctl;
  wire wr_wdtctl   = avs_write_i && ack_r && sel_wdtctl;

  wire [31:0] rd_mux =
      sel_status ? {28'h000_0000, osc_drv_en_o, in_sleep, to_r, pd_r} :
      sel_irqctl ? {24'h00_0000, irqctl_r} :
      sel_wdtctl ? {31'h0000_0000, wdt_en_r} :
      sel_wdtcnt ? {16'h0000, wdt_cnt_r} : SWC_RD_UNMAPPED;

  // Hardware sets win over software writes of a cleared flag
  wire [7:0] irq_wr  = wr_irqctl ? avs_writedata_i[7:0] : irqctl_r;
  wire [7:0] irq_set = {1'b0, set_cmif, 3'b000, 1'b0, set_edge_irq_flag, set_port_change_flag};
  wire [7:0] irq_nxt = irq_wr | irq_set;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SWC_RUN:    if (sleep_go) state_nxt = SWC_SLEEP;
      SWC_SLEEP:  if (wake_any) state_nxt = SWC_OST;
      SWC_OST:    if (ost_done) state_nxt = SWC_RESUME;
      SWC_RESUME: state_nxt = (global_irq_enable && !wake_wdt_r) ? SWC_VECTOR : SWC_RUN;
      SWC_VECTOR: state_nxt = SWC_RUN;
      default:    state_nxt = SWC_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || master_clear_pin_rst) begin
      state_r <= SWC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Power-up flag survives master clear; only power-on reset and clrwdt_i while running set it
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pd_r       <= 1'b1;
      to_r       <= 1'b1;
      por_done_r <= 1'b0;
    end else begin
      por_done_r <= 1'b1;
      if (sleep_go) begin
        pd_r <= 1'b0;
        to_r <= 1'b1;
      end else if (wake_wdt) begin
        to_r <= 1'b0;
      end else if (running && wdt_expire) begin
        to_r <= 1'b0;
      end else if (clrwdt_i && running) begin
        pd_r <= 1'b1;
        to_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || master_clear_pin_rst) begin
      irqctl_r <= SWC_IRQCTL_RST;
    end else begin
      irqctl_r <= irq_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wdt_en_r <= 1'b0;
    end else if (wr_wdtctl) begin
      wdt_en_r <= avs_writedata_i[SWC_WC_EN];
    end
  end

  // Watchdog counts on clk_i, which keeps running in sleep, so it keeps counting in sleep
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || master_clear_pin_rst) begin
      wdt_cnt_r <= '0;
    end else if (sleep_go || wake_any || clrwdt_i || !wdt_en_r || wdt_expire) begin
      wdt_cnt_r <= '0;
    end else begin
      wdt_cnt_r <= wdt_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !(state_r == SWC_OST)) begin
      ost_cnt_r <= '0;
    end else begin
      ost_cnt_r <= ost_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      port_hi_q_r <= '0;
      wake_wdt_r  <= 1'b0;
      resume_pc_r <= '0;
    end else begin
      port_hi_q_r <= port_hi_i;
      if (wake_any) begin
        wake_wdt_r <= wake_wdt && !wake_irq;
      end
      if (sleep_go) begin
        resume_pc_r <= pc_i + 13'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      osc_drv_en_o      <= 1'b1;
      core_run_o        <= 1'b0;
      prefetch_o        <= 1'b0;
      fetch_addr_o      <= '0;
      vector_o          <= 1'b0;
      dev_reset_o       <= 1'b1;
      master_clear_oe_o <= 1'b0;
      port_pin_o        <= '0;
      avs_readdata_o    <= '0;
      avs_waitrequest_o <= 1'b1;
      ack_r             <= 1'b0;
    end else begin
      osc_drv_en_o      <= !(state_nxt == SWC_SLEEP) || master_clear_pin_rst;
      core_run_o        <= (state_nxt == SWC_RUN) && !master_clear_pin_rst;
      prefetch_o        <= sleep_go;
      fetch_addr_o      <= (state_nxt == SWC_VECTOR) ? SWC_IRQ_VECTOR :
                           (sleep_go ? pc_i + 13'h0001 : resume_pc_r);
      vector_o          <= (state_nxt == SWC_VECTOR);
      dev_reset_o       <= master_clear_pin_rst || !por_done_r || (running && wdt_expire);
      master_clear_oe_o <= 1'b0;
      if (!(state_nxt == SWC_SLEEP) || master_clear_pin_rst) begin
        port_pin_o <= port_core_i;
      end
      ack_r             <= req;
      avs_waitrequest_o <= !req;
      if (req) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sleep_entry_a:  assert property (running && sleep_exec_i && !master_clear_pin_rst |=> in_sleep)
    else $error("sleep not entered");
  sleep_flags_a:  assert property (sleep_go |=> !pd_r && to_r)
    else $error("flags wrong after sleep");
  osc_off_a:      assert property (sleep_go && !master_clear_pin_rst |=> !osc_drv_en_o)
    else $error("oscillator still on in sleep");
  port_hold_a:    assert property (in_sleep && !wake_any && !master_clear_pin_rst |=> $stable(port_pin_o))
    else $error("port moved in sleep");
  master_clear_pin_never_a:   assert property (!master_clear_oe_o)
    else $error("master clear driven");
  wdt_clear_a:    assert property (wake_any && !master_clear_pin_rst |=> wdt_cnt_r == '0)
    else $error("watchdog not cleared on wake");
  wake_to_a:      assert property (wake_wdt && !master_clear_pin_rst |=> !to_r)
    else $error("time-out flag not cleared");
  ost_wait_a:     assert property (wake_any && !master_clear_pin_rst |=> !core_run_o [*8])
    else $error("core resumed before start-up");
  vector_gie_a:   assert property (state_r == SWC_RESUME && !global_irq_enable && !master_clear_pin_rst |=> !vector_o)
    else $error("vectored with global enable clear");
  master_clear_pin_reset_a:   assert property (master_clear_pin_rst |=> dev_reset_o)
    else $error("master clear did not reset");
  wake_irq_a:     assert property (wake_irq && !master_clear_pin_rst |=> state_r == SWC_OST)
    else $error("interrupt wake missed");

  sleep_cov_c:    cover property (sleep_go);
  wake_wdt_c:     cover property (wake_wdt);
  wake_irq_c:     cover property (wake_irq ##[1:1000] vector_o);
  master_clear_pin_sleep_c:   cover property (in_sleep && master_clear_pin_rst);
endmodule
`default_nettype wire

// [testbench/swc_src_model.sv]
/*
  Stand-in for what surrounds the sleep controller: master clear pin, upper
  port pins and interrupt source pulses. Assumes the bench raises requests.
*/
`default_nettype none
module swc_src_model (
  // Clock
  input  wire logic         clk_i,
  // Requests from the bench
  input  wire logic         master_clear_pin_req_i,
  input  wire logic         edge_req_i,
  input  wire logic         cmp_req_i,
  input  wire logic [7:4]   port_req_i,
  // Pins toward the controller
  output logic              master_clear_pin_n_o,
  output logic      [7:4]   port_hi_o,
  output swc_pkg::swc_src_t src_evt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import swc_pkg::*;

  initial begin
    master_clear_pin_n_o = 1'b1;
    port_hi_o            = 4'h0;
    src_evt_o            = '0;
  end

  // Pin stays high unless a reset is asked; events last one cycle
  always @(posedge clk_i) begin
    master_clear_pin_n_o <= ~master_clear_pin_req_i;
    port_hi_o            <= port_req_i;
    src_evt_o            <= '{edge_irq_pin: edge_req_i, port_hi_change: 1'b0, cmp_change: cmp_req_i};
  end
endmodule
`default_nettype wire

// [testbench/test_swc_core.sv]
/*
  Self-checking bench for the sleep and wake-up controller: bus tasks,
  sleep entry and the wake-up paths. Assumes the source model beside it.
*/
`default_nettype none
module test_swc_core;
  timeunit 1ns;
  timeprecision 1ps;
  import swc_pkg::*;

  logic        clk_i, reset_n, rd, wr, sl, master_clear_pin_q, edge_q, cmp_q;
  logic        waitreq, prefetch, run, vec, osc, dev_rst, mc_oe, master_clear_pin_n;
  logic        oe_seen, rst_seen;
  logic [3:0]  adr;
  logic [7:4]  port_q, port_hi;
  logic [12:0] pcv, faddr, vec_addr;
  logic [31:0] wdata, rdata, q;
  swc_src_t    src;
  swc_port_t   port_core, port_pin;
  int          error_cnt, n_checks, vec_cnt, c;

  swc_src_model u_src (.clk_i(clk_i), .master_clear_pin_req_i(master_clear_pin_q), .edge_req_i(edge_q), .cmp_req_i(cmp_q),
    .port_req_i(port_q), .master_clear_pin_n_o(master_clear_pin_n), .port_hi_o(port_hi), .src_evt_o(src));

  swc_core dut (.clk_i(clk_i), .reset_n_i(reset_n), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .sleep_exec_i(sl), .clrwdt_i(1'b0), .pc_i(pcv), .prefetch_o(prefetch), .fetch_addr_o(faddr),
    .core_run_o(run), .vector_o(vec), .master_clear_pin_n_i(master_clear_pin_n), .port_hi_i(port_hi),
    .src_evt_i(src), .port_core_i(port_core), .port_pin_o(port_pin), .osc_drv_en_o(osc),
    .dev_reset_o(dev_rst), .master_clear_oe_o(mc_oe));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Monitors for pulses that a sequential test would miss
  always @(posedge clk_i) begin
    if (vec === 1'b1) begin
      vec_cnt  <= vec_cnt + 1;
      vec_addr <= faddr;
    end
    if (reset_n && mc_oe !== 1'b0) oe_seen <= 1'b1;
    if (dev_rst === 1'b1) rst_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr   <= a;
    wdata <= d;
    rd    <= ~w;
    wr    <= w;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    q = rdata;
    chk("waitrequest", 32'h0, {31'h0, waitreq});
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask

  task automatic do_sleep(input logic [12:0] p);
    pcv <= p;
    sl  <= 1'b1;
    @(posedge clk_i);
    sl <= 1'b0;
    #1;
    chk("prefetch", 32'h1, {31'h0, prefetch});
    chk("fetch addr", {19'h0, p + 13'h0001}, {19'h0, faddr});
    chk("osc drive", 32'h0, {31'h0, osc});
    chk("core run", 32'h0, {31'h0, run});
    @(posedge clk_i);
  endtask

  task automatic pulse(input int which);
    if (which == 0) edge_q <= 1'b1;
    else cmp_q <= 1'b1;
    @(posedge clk_i);
    edge_q <= 1'b0;
    cmp_q  <= 1'b0;
  endtask

  task automatic wait_run(input int lim);
    c = 0;
    while (run !== 1'b1 && c < lim) begin
      @(posedge clk_i);
      c++;
    end
    chk("woke", 32'h1, {31'h0, run});
  endtask

  task automatic finish_test();
    chk("clear pin drive", 32'h0, {31'h0, oe_seen});
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog wake alone needs some 67000 cycles
  initial begin
    #(4 * 95_000);
    error_cnt++;
    $display("unexpected timeout: expected end, seen hang");
    finish_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {reset_n, rd, wr, sl, master_clear_pin_q, edge_q, cmp_q, oe_seen, rst_seen} = '0;
    {adr, port_q, pcv, wdata, vec_addr} = '0;
    port_core = '{out: 8'hA5, oe: 8'h0F};
    error_cnt = 0;
    n_checks  = 0;
    vec_cnt   = 0;
    repeat (5) @(posedge clk_i);
    reset_n <= 1'b1;
    @(posedge clk_i);
    rd_chk("status", SWC_ADDR_STATUS, 32'h3, 32'h3);
    rd_chk("irq control", SWC_ADDR_IRQCTL, 32'hFF, {24'h0, SWC_IRQCTL_RST});
    rd_chk("unmapped", 4'h2, 32'hFFFF_FFFF, SWC_RD_UNMAPPED);
    chk("osc idle", 32'h1, {31'h0, osc});
    $display("test reset done");
    // Edge pin wake, global enable clear
    bus(1'b1, SWC_ADDR_IRQCTL, 32'h1 << SWC_IC_EDGE_IRQ_ENABLE);
    do_sleep(13'h0100);
    port_core <= '{out: 8'h5A, oe: 8'hF0};
    repeat (4) @(posedge clk_i);
    chk("port hold", 32'h0000_A50F, {16'h0, port_pin});
    pulse(0);
    wait_run(1200);
    chk("start-up wait", 32'h1, {31'h0, c >= SWC_OST_CYC});
    repeat (4) @(posedge clk_i);
    chk("port follows", 32'h0000_5AF0, {16'h0, port_pin});
    chk("vector count", 32'h0, vec_cnt);
    rd_chk("status", SWC_ADDR_STATUS, 32'h3, 32'h2);
    $display("test edge wake done");
    // Port change wake, global enable set
    bus(1'b1, SWC_ADDR_IRQCTL, (32'h1 << SWC_IC_GIE) | (32'h1 << SWC_IC_PORT_CHANGE_ENABLE));
    do_sleep(13'h0200);
    port_q <= 4'h9;
    wait_run(1200);
    repeat (4) @(posedge clk_i);
    chk("vector count", 32'h1, vec_cnt);
    chk("vector addr", {19'h0, SWC_IRQ_VECTOR}, {19'h0, vec_addr});
    $display("test vector wake done");
    // Disabled source, then master clear
    bus(1'b1, SWC_ADDR_IRQCTL, 32'h0);
    do_sleep(13'h0300);
    pulse(1);
    repeat (60) @(posedge clk_i);
    chk("disabled source", 32'h0, {30'h0, run, osc});
    master_clear_pin_q <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk("clear reset", 32'h1, {31'h0, dev_rst});
    @(posedge clk_i);
    master_clear_pin_q <= 1'b0;
    wait_run(1500);
    rd_chk("irq control", SWC_ADDR_IRQCTL, 32'hFF, {24'h0, SWC_IRQCTL_RST});
    rd_chk("status", SWC_ADDR_STATUS, 32'h3, 32'h2);
    $display("test master clear done");
    // Pending enabled flag wakes at once
    bus(1'b1, SWC_ADDR_IRQCTL, 32'h1 << SWC_IC_CMIE);
    pulse(1);
    repeat (3) @(posedge clk_i);
    rd_chk("irq control", SWC_ADDR_IRQCTL, 32'hFF, 32'h60);
    vec_cnt <= 0;
    do_sleep(13'h0400);
    wait_run(1200);
    chk("vector count", 32'h0, vec_cnt);
    bus(1'b1, SWC_ADDR_IRQCTL, 32'h0);
    $display("test pending wake done");
    // Watchdog wake
    bus(1'b1, SWC_ADDR_WDTCTL, 32'h1 << SWC_WC_EN);
    rst_seen <= 1'b0;
    do_sleep(13'h0500);
    wait_run(70000);
    chk("reset on wake", 32'h0, {31'h0, rst_seen});
    rd_chk("status", SWC_ADDR_STATUS, 32'h3, 32'h0);
    bus(1'b0, SWC_ADDR_WDTCNT, 32'h0);
    chk("count cleared", 32'h1, {31'h0, q < 32'h0000_0800});
    $display("test watchdog wake done");
    finish_test();
  end
endmodule
`default_nettype wire
